// ==== pkg/acr_pkg.sv ====
// Package with register map, field positions, reset values and types of the converter control block.
package acr_pkg;

   // Register offsets. 0x79 to 0x7b are not multiples of four, so each offset is an
   // index and the byte address is four times the index.
   localparam logic [7:0] RESULT_LOW_IDX   = 8'h78;
   localparam logic [7:0] RESULT_HIGH_IDX  = 8'h79;
   localparam logic [7:0] CONTROL_A_IDX    = 8'h7a;
   localparam logic [7:0] CONTROL_B_IDX    = 8'h7b;
   localparam logic [7:0] INPUT_REF_IDX    = 8'h7c;

   // Field positions in control register A.
   localparam int CA_ENABLE   = 7;
   localparam int CA_START    = 6;
   localparam int CA_AUTO     = 5;
   localparam int CA_DONE     = 4;
   localparam int CA_IRQ_EN   = 3;

   // Field positions in the input and reference select register.
   localparam int IR_LEFT_ADJ = 5;

   // Reset values.
   localparam logic [7:0] CONTROL_A_RST = 8'h00;
   localparam logic [7:0] CONTROL_B_RST = 8'h00;
   localparam logic [7:0] INPUT_REF_RST = 8'h00;
   localparam logic [9:0] RESULT_RST    = 10'h000;

   // Conversion lengths in converter clock cycles.
   localparam logic [4:0] FIRST_CONV_CYCLES  = 5'd25;
   localparam logic [4:0] NORMAL_CONV_CYCLES = 5'd13;

   // Reference and channel codes.
   localparam logic [1:0] REF_EXTERNAL = 2'h0;
   localparam logic [1:0] REF_SUPPLY   = 2'h1;
   localparam logic [1:0] REF_RESERVED = 2'h2;
   localparam logic [1:0] REF_INTERNAL = 2'h3;
   localparam logic [3:0] CH_BANDGAP   = 4'he;
   localparam logic [3:0] CH_GROUND    = 4'hf;

   // Trigger source codes.
   localparam logic [2:0] TRIG_FREE_RUN = 3'h0;

   typedef enum logic [2:0] {
      ACR_TRIG_FREE,
      ACR_TRIG_COMPARATOR,
      ACR_TRIG_EXT_INT0,
      ACR_TRIG_T0_CMP_A,
      ACR_TRIG_T0_OVF,
      ACR_TRIG_T1_CMP_B,
      ACR_TRIG_T1_OVF,
      ACR_TRIG_T1_CAPTURE
   } acr_trig_t;

   // Selections handed to the conversion core.
   typedef struct packed {
      logic [1:0] reference_select;
      logic [3:0] channel_select;
   } acr_sel_t;

   // External trigger flags, one per nonzero trigger code.
   typedef struct packed {
      logic timer1_capture;
      logic timer1_overflow;
      logic timer1_compare_b;
      logic timer0_overflow;
      logic timer0_compare_a;
      logic ext_interrupt0;
      logic comparator;
   } acr_trig_flags_t;

endpackage : acr_pkg

// ==== hdl/acr_sar_core.sv ====
// Conversion core stand-in: counts converter clocks and delivers a result with a done pulse.
`timescale 1ns/10ps
`default_nettype none
module acr_sar_core (
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic            ce,
   input  wire logic            conv_tick,
   input  wire logic            start,
   input  wire logic            abort,
   input  wire logic            first,
   input  wire acr_pkg::acr_sel_t sel,
   input  wire logic [9:0]      sample_code,
   output logic                 busy,
   output logic                 done,
   output logic [9:0]           result
);
   typedef struct packed {
      logic       busy;
      logic       done;
      logic [4:0] count;
      logic [9:0] result;
   } acr_core_state_t;

   acr_core_state_t st_r;
   acr_core_state_t st_nxt;

   always_comb begin
      st_nxt      = st_r;
      st_nxt.done = 1'b0;
      if (abort) begin
         st_nxt.busy = 1'b0;
      end else if (start && !st_r.busy) begin
         st_nxt.busy  = 1'b1;
         st_nxt.count = first ? acr_pkg::FIRST_CONV_CYCLES : acr_pkg::NORMAL_CONV_CYCLES;
      end else if (st_r.busy && conv_tick) begin
         if (st_r.count == 5'h01) begin
            st_nxt.busy = 1'b0;
            st_nxt.done = 1'b1;
            // Ground channel always reads as zero; other inputs come from the sample port.
            st_nxt.result = (sel.channel_select == acr_pkg::CH_GROUND) ? 10'h000 : sample_code;
         end else begin
            st_nxt.count = st_r.count - 5'h01;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign busy   = st_r.busy;
   assign done   = st_r.done;
   assign result = st_r.result;
endmodule : acr_sar_core
`default_nettype wire

// ==== hdl/acr_control.sv ====
// Converter control and register block with an APB slave port.
//
// Function
// - Reference code 00 external pin, 01 supply, 10 reserved, 11 internal 1.1V.
// - A reference change during a conversion waits until that conversion completes.
// - Left adjust bit changes result presentation immediately, even mid-conversion.
// - Channel codes 0-7 inputs, 1110 bandgap, 1111 ground; changes wait for completion.
// - Bit 4 of the select register always reads zero.
// - Enable bit powers the converter; clearing it aborts any running conversion.
// - Writing start begins a conversion; free running needs only the first start.
// - First conversion after enabling takes 25 converter clocks, later ones 13.
// - Start bit reads one while converting; writing zero to it does nothing.
// - Auto trigger starts a conversion on each rising edge of the selected source.
// - Done flag sets when a conversion completes and the result is updated.
// - Done flag clears on interrupt acknowledge or when software writes one.
// - Interrupt requested while done flag, its enable and global enable are set.
// - Prescaler codes give divide by 2,2,4,8,16,32,64,128.
// - Result is a 10-bit code, input times 1024 over reference.
// - Right adjust puts bits 9:8 high, 7:0 low; left adjust 9:2 high, 1:0 low top.
// - Reading the low byte blocks result updates until the high byte is read.
// - Trigger source field acts only with auto trigger; rising flag edge triggers.
// - Switching from a clear source to a set source counts as a rising edge.
// - Trigger codes: free run, comparator, int0, t0 cmp A, t0 ovf, t1 cmp B, ovf, capture.
// - Switching to free running mode itself creates no trigger event.
`timescale 1ns/10ps
`default_nettype none
module acr_control (
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     ce,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [11:0]              paddr,
   input  wire logic [31:0]              pwdata,
   output logic [31:0]                   prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire acr_pkg::acr_trig_flags_t trig_flags,
   input  wire logic                     global_irq_enable,
   input  wire logic                     irq_ack,
   input  wire logic [9:0]               sample_code,
   output logic                          irq,
   output logic                          converter_power,
   output logic                          conv_clk_tick,
   output acr_pkg::acr_sel_t             active_sel
);
   typedef struct packed {
      logic [7:0]        ctrl_a;
      logic [2:0]        trig_src;
      logic [7:0]        in_ref;
      acr_pkg::acr_sel_t act_sel;
      logic              first_pend;
      logic              trig_level;
      logic              start_pend;
      logic [9:0]        result;
      logic [9:0]        held;
      logic              read_lock;
      logic [6:0]        presc;
      logic [31:0]       rdata;
   } acr_state_t;

   acr_state_t st_r;
   acr_state_t st_nxt;

   logic       core_busy;
   logic       core_done;
   logic [9:0] core_result;
   logic       core_start;
   logic       tick;
   logic       sel_level;
   logic [6:0] div_mask;
   logic [7:0] high_byte;
   logic [7:0] low_byte;
   logic       wr;
   logic       rd;
   logic [9:0] idx;
   logic       mapped;

   assign idx    = paddr[11:2];
   assign wr     = psel && penable && pwrite;
   assign rd     = psel && penable && !pwrite;
   assign mapped = paddr[1:0] == 2'h0 && idx >= {2'h0, acr_pkg::RESULT_LOW_IDX}
                   && idx <= {2'h0, acr_pkg::INPUT_REF_IDX};

   // Prescaler mask: counter bits that must all be ones for a converter clock tick.
   always_comb begin
      unique case (st_r.ctrl_a[2:0])
         3'h0, 3'h1: div_mask = 7'h01;
         3'h2:       div_mask = 7'h03;
         3'h3:       div_mask = 7'h07;
         3'h4:       div_mask = 7'h0f;
         3'h5:       div_mask = 7'h1f;
         3'h6:       div_mask = 7'h3f;
         3'h7:       div_mask = 7'h7f;
      endcase
   end
   // Gated by the clock enable so that a frozen prescaler cannot repeat a tick.
   assign tick = ((st_r.presc & div_mask) == div_mask) && st_r.ctrl_a[acr_pkg::CA_ENABLE]
                 && ce;

   // Selected trigger flag; code zero has no flag of its own.
   always_comb begin
      unique case (acr_pkg::acr_trig_t'(st_r.trig_src))
         acr_pkg::ACR_TRIG_FREE:       sel_level = 1'b0;
         acr_pkg::ACR_TRIG_COMPARATOR: sel_level = trig_flags.comparator;
         acr_pkg::ACR_TRIG_EXT_INT0:   sel_level = trig_flags.ext_interrupt0;
         acr_pkg::ACR_TRIG_T0_CMP_A:   sel_level = trig_flags.timer0_compare_a;
         acr_pkg::ACR_TRIG_T0_OVF:     sel_level = trig_flags.timer0_overflow;
         acr_pkg::ACR_TRIG_T1_CMP_B:   sel_level = trig_flags.timer1_compare_b;
         acr_pkg::ACR_TRIG_T1_OVF:     sel_level = trig_flags.timer1_overflow;
         acr_pkg::ACR_TRIG_T1_CAPTURE: sel_level = trig_flags.timer1_capture;
      endcase
   end

   // Result presentation follows the left adjust bit combinationally.
   always_comb begin
      if (st_r.in_ref[acr_pkg::IR_LEFT_ADJ]) begin
         high_byte = st_r.result[9:2];
         low_byte  = {st_r.result[1:0], 6'h00};
      end else begin
         high_byte = {6'h00, st_r.result[9:8]};
         low_byte  = st_r.result[7:0];
      end
   end

   always_comb begin
      logic       en_now;
      logic       en_was;
      logic       auto_ev;
      logic       sw_start;
      logic       free_ev;
      logic [7:0] wb;
      en_now   = 1'b0;
      en_was   = 1'b0;
      auto_ev  = 1'b0;
      sw_start = 1'b0;
      free_ev  = 1'b0;
      wb       = pwdata[7:0];
      st_nxt   = st_r;
      core_start = 1'b0;
      st_nxt.presc = st_r.ctrl_a[acr_pkg::CA_ENABLE] ? st_r.presc + 7'h01 : 7'h00;
      en_was = st_r.ctrl_a[acr_pkg::CA_ENABLE];

      // Register writes.
      if (wr && mapped) begin
         unique case (idx[7:0])
            acr_pkg::CONTROL_A_IDX: begin
               st_nxt.ctrl_a[7]   = wb[7];
               st_nxt.ctrl_a[5]   = wb[5];
               st_nxt.ctrl_a[3:0] = wb[3:0];
               sw_start = wb[acr_pkg::CA_START] && wb[acr_pkg::CA_ENABLE];
               if (wb[acr_pkg::CA_DONE]) begin
                  st_nxt.ctrl_a[acr_pkg::CA_DONE] = 1'b0;
               end
            end
            acr_pkg::CONTROL_B_IDX: st_nxt.trig_src = wb[2:0];
            acr_pkg::INPUT_REF_IDX: st_nxt.in_ref = {wb[7:5], 1'b0, wb[3:0]};
            default: ;
         endcase
      end
      if (irq_ack) begin
         st_nxt.ctrl_a[acr_pkg::CA_DONE] = 1'b0;
      end
      en_now = st_nxt.ctrl_a[acr_pkg::CA_ENABLE];
      if (en_now && !en_was) begin
         st_nxt.first_pend = 1'b1;
      end
      if (!en_now) begin
         st_nxt.start_pend = 1'b0;
      end

      // Free running restarts on every completion once the first start was given.
      free_ev = core_done && st_r.trig_src == acr_pkg::TRIG_FREE_RUN
                && st_r.ctrl_a[acr_pkg::CA_AUTO];

      // A rising edge of the selected level, including one made by a source switch.
      st_nxt.trig_level = sel_level;
      auto_ev = st_r.ctrl_a[acr_pkg::CA_AUTO] && sel_level && !st_r.trig_level;

      if ((sw_start || auto_ev || free_ev) && en_now) begin
         st_nxt.start_pend = 1'b1;
      end

      // Selections latch into the core only at a start, so writes mid-conversion wait.
      if (st_r.start_pend && !core_busy && en_now && !core_done) begin
         core_start           = 1'b1;
         st_nxt.start_pend    = 1'b0;
         st_nxt.first_pend    = 1'b0;
         st_nxt.act_sel       = acr_sel_f(st_nxt.in_ref);
      end
      // The start cycle itself counts as converting, so the bit has no gap before busy rises.
      st_nxt.ctrl_a[acr_pkg::CA_START] = st_nxt.start_pend || core_start
                                          || (core_busy && !core_done && en_now);

      // Completion: the result waits in the held value while the low byte lock stands.
      if (core_done && en_was) begin
         st_nxt.held = core_result;
         st_nxt.ctrl_a[acr_pkg::CA_DONE] = 1'b1;
      end
      if (!st_r.read_lock) begin
         st_nxt.result = (core_done && en_was) ? core_result : st_r.held;
      end

      // Read path and the result lock.
      st_nxt.rdata = 32'h0000_0000;
      if (psel && !penable && !pwrite && mapped) begin
         unique case (paddr[9:2])
            acr_pkg::RESULT_LOW_IDX:  st_nxt.rdata = {24'h000000, low_byte};
            acr_pkg::RESULT_HIGH_IDX: st_nxt.rdata = {24'h000000, high_byte};
            acr_pkg::CONTROL_A_IDX:   st_nxt.rdata = {24'h000000, st_r.ctrl_a};
            acr_pkg::CONTROL_B_IDX:   st_nxt.rdata = {29'h0000000, st_r.trig_src};
            acr_pkg::INPUT_REF_IDX:   st_nxt.rdata = {24'h000000, st_r.in_ref};
            default: ;
         endcase
      end
      if (rd && mapped && idx[7:0] == acr_pkg::RESULT_LOW_IDX) begin
         st_nxt.read_lock = 1'b1;
      end
      if (rd && mapped && idx[7:0] == acr_pkg::RESULT_HIGH_IDX) begin
         st_nxt.read_lock = 1'b0;
      end
   end

   function automatic acr_pkg::acr_sel_t acr_sel_f(input logic [7:0] r);
      acr_pkg::acr_sel_t s;
      s.reference_select = r[7:6];
      s.channel_select   = r[3:0];
      return s;
   endfunction : acr_sel_f

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r        <= '0;
         st_r.ctrl_a <= acr_pkg::CONTROL_A_RST;
         st_r.in_ref <= acr_pkg::INPUT_REF_RST;
         st_r.result <= acr_pkg::RESULT_RST;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   acr_sar_core u_core (
      .pclk        (pclk),
      .presetn     (presetn),
      .ce          (ce),
      .conv_tick   (tick),
      .start       (core_start),
      .abort       (!st_r.ctrl_a[acr_pkg::CA_ENABLE]),
      .first       (st_r.first_pend),
      .sel         (st_nxt.act_sel),
      .sample_code (sample_code),
      .busy        (core_busy),
      .done        (core_done),
      .result      (core_result)
   );

   assign prdata          = st_r.rdata;
   assign pready          = 1'b1;
   assign pslverr         = psel && penable && !mapped;
   assign irq             = st_r.ctrl_a[acr_pkg::CA_DONE] && st_r.ctrl_a[acr_pkg::CA_IRQ_EN]
                            && global_irq_enable;
   assign converter_power = st_r.ctrl_a[acr_pkg::CA_ENABLE];
   assign conv_clk_tick   = tick;
   assign active_sel      = st_r.act_sel;
endmodule : acr_control
`default_nettype wire

// ==== verification/acr_far_side.sv ====
// Far-side model: the code the analog core delivers and the on-chip trigger flags.
`timescale 1ns/10ps
`default_nettype none
module acr_far_side (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic [9:0]          code_req,
   input  wire logic [6:0]          flag_req,
   output logic [9:0]               sample_code,
   output acr_pkg::acr_trig_flags_t trig_flags
);
   // Flags move only at a clock edge, as the on-chip sources that raise them do.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_code <= 10'h000;
         trig_flags  <= 7'h00;
      end else begin
         sample_code <= code_req;
         trig_flags  <= flag_req;
      end
   end
endmodule : acr_far_side
`default_nettype wire

// ==== verification/acr_control_assertions.sv ====
// Port-level assertions for the converter control block.
`timescale 1ns/10ps
`default_nettype none
module acr_control_checker (
   input wire logic                     pclk,
   input wire logic                     presetn,
   input wire logic                     ce,
   input wire logic                     psel,
   input wire logic                     penable,
   input wire logic                     pwrite,
   input wire logic [11:0]              paddr,
   input wire logic [31:0]              pwdata,
   input wire logic [31:0]              prdata,
   input wire logic                     pready,
   input wire logic                     pslverr,
   input wire acr_pkg::acr_trig_flags_t trig_flags,
   input wire logic                     global_irq_enable,
   input wire logic                     irq_ack,
   input wire logic [9:0]               sample_code,
   input wire logic                     irq,
   input wire logic                     converter_power,
   input wire logic                     conv_clk_tick,
   input wire acr_pkg::acr_sel_t        active_sel
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire acc   = psel && penable;
   wire ca_wr = acc && pwrite && paddr == 12'h1e8;
   wire ca_rd = acc && !pwrite && paddr == 12'h1e8;
   wire bad   = paddr < 12'h1e0 || paddr > 12'h1f0 || paddr[1:0] != 2'b00;
   upper_zero_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h000000)
      else $error("read data upper bits set");
   slave_error_a: assert property (acc |-> pslverr == bad && pready)
      else $error("error response wrong");
   bit4_zero_a: assert property (acc && !pwrite && paddr == 12'h1f0 |-> !prdata[4])
      else $error("select bit 4 reads one");
   irq_request_a: assert property (ca_rd && prdata[4] && prdata[3]
      && global_irq_enable && !$past(irq_ack) |-> irq)
      else $error("interrupt not requested");
   power_on_a: assert property ($rose(converter_power) |-> $past(ca_wr && pwdata[7]))
      else $error("power rose without enable write");
   power_off_a: assert property ($fell(converter_power) |-> $past(ca_wr && !pwdata[7]))
      else $error("power fell without disable write");
   tick_gap_a: assert property (conv_clk_tick |=> !conv_clk_tick)
      else $error("converter clock faster than half rate");
   start_off_a: assert property (ca_rd && !$past(converter_power)
      && !$past(converter_power, 2) |-> !prdata[6])
      else $error("start bit set while powered off");
   irq_gate_a: assert property (!global_irq_enable |-> !irq)
      else $error("interrupt without global enable");
   freeze_tick_a: assert property (!ce |-> !conv_clk_tick)
      else $error("converter clock ticks while frozen");
   cover property ($rose(irq));
   cover property (acc && pslverr);
   cover property ($fell(converter_power));
endmodule : acr_control_checker
`default_nettype wire

// ==== verification/test_adc_control_registers.sv ====
// Self-checking bench for the converter control block.
`timescale 1ns/10ps
`default_nettype none
module test_adc_control_registers;
   logic                     pclk = 1'b0;
   logic                     presetn = 1'b0;
   logic                     psel = 1'b0;
   logic                     penable = 1'b0;
   logic                     pwrite = 1'b0;
   logic [11:0]              paddr = 12'h000;
   logic [31:0]              pwdata = 32'h0;
   logic                     ack = 1'b0;
   logic                     ce = 1'b1;
   logic                     gie = 1'b1;
   logic [9:0]               code_req = 10'h000;
   logic [6:0]               flag_req = 7'h00;
   logic [31:0]              prdata;
   logic                     pready, pslverr, irq, power, tick, err;
   logic [9:0]               code, old;
   logic [7:0]               rd;
   acr_pkg::acr_trig_flags_t flags;
   acr_pkg::acr_sel_t        asel;
   int                       tcount = 0;
   int                       n_mismatch = 0;
   int                       checks_done = 0;

   acr_far_side u_far (.pclk(pclk), .presetn(presetn), .code_req(code_req),
      .flag_req(flag_req), .sample_code(code), .trig_flags(flags));
   acr_control u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig_flags(flags),
      .global_irq_enable(gie), .irq_ack(ack), .sample_code(code), .irq(irq),
      .converter_power(power), .conv_clk_tick(tick), .active_sel(asel));

   initial begin
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      tcount <= tcount + int'(tick === 1'b1);
   end

   function automatic logic [7:0] exp_byte(logic [9:0] c, logic la, logic hi);
      if (hi) begin
         return la ? c[9:2] : {6'h00, c[9:8]};
      end
      return la ? {c[1:0], 6'h00} : c[7:0];
   endfunction : exp_byte

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic finish_test();
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test

   // An idle edge follows each transfer so that no strobe is driven twice in one step.
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wait_irq();
      for (int i = 0; i < 4000 && irq !== 1'b1; i++) begin
         @(posedge pclk);
      end
      check(irq, 1'b1);
   endtask : wait_irq

   task automatic run(input int n, input logic [7:0] s, input logic [5:0] cur);
      int t0;
      apb(1'b1, 8'h7a, 8'hc8);
      t0 = tcount;
      apb(1'b1, 8'h7c, s);
      apb(1'b0, 8'h7a, 8'h00);
      check(rd, 8'hc8);
      check(asel, cur);
      wait_irq();
      check(tcount - t0 inside {[n - 1:n + 1]}, 1'b1);
   endtask : run

   task automatic result(input logic [9:0] c, input logic la);
      apb(1'b0, 8'h78, 8'h00);
      check(rd, exp_byte(c, la, 1'b0));
      apb(1'b0, 8'h79, 8'h00);
      check(rd, exp_byte(c, la, 1'b1));
   endtask : result

   initial begin
      int c;
      old = 10'($urandom(32'hdfd0));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 8'h78; i < 8'h7d; i++) begin
         apb(1'b0, 8'(i), 8'h00);
         check(rd, 8'h00);
      end
      apb(1'b1, 8'h78, 8'hff);
      apb(1'b0, 8'h78, 8'h00);
      check(rd, 8'h00);
      // The low byte read above locks the result; the high byte read releases it.
      apb(1'b0, 8'h79, 8'h00);
      check(rd, 8'h00);
      apb(1'b1, 8'h7d, 8'h5a);
      check(err, 1'b1);
      apb(1'b1, 8'h7c, 8'h51);
      apb(1'b0, 8'h7c, 8'h00);
      check(rd, 8'h41);
      for (int p = 0; p < 8; p++) begin
         apb(1'b1, 8'h7a, 8'hc0 | 8'(p));
         while (tick !== 1'b1) @(posedge pclk);
         c = 0;
         do begin
            @(posedge pclk);
            c++;
         end while (tick !== 1'b1);
         check(c, (p < 2) ? 2 : (1 << p));
         apb(1'b1, 8'h7a, 8'h00);
         apb(1'b0, 8'h7a, 8'h00);
         check(rd, 8'h00);
      end
      code_req <= old;
      apb(1'b1, 8'h7c, 8'h41);
      run(25, 8'hc2, 6'h11);
      gie <= 1'b0;
      @(posedge pclk);
      check(irq, 1'b0);
      gie <= 1'b1;
      ce <= 1'b0;
      @(posedge pclk);
      c = tcount;
      repeat (10) @(posedge pclk);
      check(tcount - c, 0);
      ce <= 1'b1;
      apb(1'b0, 8'h7a, 8'h00);
      check(rd, 8'h98);
      result(old, 1'b0);
      apb(1'b1, 8'h7c, 8'he2);
      result(old, 1'b1);
      apb(1'b1, 8'h7a, 8'h98);
      check(irq, 1'b0);
      apb(1'b0, 8'h78, 8'h00);
      code_req <= ~old;
      run(13, 8'he2, 6'h32);
      apb(1'b0, 8'h79, 8'h00);
      check(rd, old[9:2]);
      ack <= 1'b1;
      @(posedge pclk);
      ack <= 1'b0;
      @(posedge pclk);
      check(irq, 1'b0);
      old = 10'($urandom);
      code_req <= old;
      run(13, 8'hef, 6'h32);
      result(old, 1'b1);
      apb(1'b1, 8'h7a, 8'h98);
      run(13, 8'he2, 6'h3f);
      result(10'h000, 1'b1);
      apb(1'b1, 8'h7a, 8'hb8);
      for (int s = 1; s < 8; s++) begin
         flag_req <= 7'h00;
         apb(1'b1, 8'h7b, 8'(s));
         flag_req <= 7'($urandom) & ~(7'h01 << (s - 1));
         repeat (2) @(posedge pclk);
         flag_req <= flag_req | (7'h01 << (s - 1));
         wait_irq();
         apb(1'b1, 8'h7a, 8'hb8);
      end
      flag_req <= 7'h02;
      apb(1'b1, 8'h7b, 8'h01);
      apb(1'b1, 8'h7b, 8'h02);
      wait_irq();
      apb(1'b1, 8'h7b, 8'h00);
      repeat (20) @(posedge pclk);
      apb(1'b0, 8'h7a, 8'h00);
      check(rd, 8'hb8);
      apb(1'b1, 8'h7a, 8'hf8);
      wait_irq();
      apb(1'b1, 8'h7a, 8'hb8);
      wait_irq();
      finish_test();
   end

   initial begin
      #400000;
      n_mismatch++;
      finish_test();
   end
endmodule : test_adc_control_registers

bind acr_control acr_control_checker u_chk (.pclk(pclk), .presetn(presetn), .ce(ce),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig_flags(trig_flags),
   .global_irq_enable(global_irq_enable), .irq_ack(irq_ack), .sample_code(sample_code),
   .irq(irq), .converter_power(converter_power), .conv_clk_tick(conv_clk_tick),
   .active_sel(active_sel));
`default_nettype wire
